// File: rtl/fms_select.sv
/*
 Floating-point min/max/min-magnitude/max-magnitude selection unit.
 Assumes request fields come from logic on clk_in; result appears one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Max writes the operand with the greater value.
// - Min writes the operand with the lesser value.
// - Max-magnitude writes the operand of larger absolute value with its own sign.
// - Min-magnitude writes the operand of smaller absolute value with its own sign.
// - Max-magnitude with equal magnitudes returns the signed larger operand.
// - Min-magnitude with equal magnitudes returns the signed smaller operand.
// - With exactly one NaN operand the numeric operand is returned unchanged.
// - With two NaNs the first source NaN is returned with its sign intact.
// - A signalling NaN with invalid trap enabled raises the trap and blocks the write.
// - A disabled coprocessor raises coprocessor-unusable for coprocessor 1 first.
// - An unimplemented format raises reserved-instruction.
// - Only invalid and unimplemented flags may be raised, never inexact, overflow, underflow.
module fms_select
  import fms_pkg::*;
#(
  parameter bit SINGLE_IMPL = 1'b1,
  parameter bit DOUBLE_IMPL = 1'b1
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire fms_req_t req_in,
  input wire logic cop1_enable_in,
  input wire logic invalid_trap_en_in,
  output fms_rsp_t rsp_out
);
  // A unit with neither format implemented could only ever refuse requests.
  if (!SINGLE_IMPL && !DOUBLE_IMPL)
  begin : g_fmt_check
    $error("fms_select needs at least one format");
  end

  // Signed-magnitude to a key that orders correctly as unsigned; -0 sits below +0.
  function automatic logic [63:0] order_key(input logic [63:0] v);
    order_key = v[63] ? ~v : {1'b1, v[62:0]};
  endfunction

  function automatic logic [63:0] widen(input logic [63:0] v, input logic dbl);
    widen = dbl ? v : {v[31:0], 32'h0};
  endfunction

  // The NaN test works on the raw operand, because a widened single would put
  // three fraction bits into the double exponent field.
  function automatic logic is_nan(input logic [63:0] v, input logic dbl);
    if (dbl)
    begin
      is_nan = (v[62:52] == 11'h7ff) && (v[51:0] != 52'h0);
    end
    else
    begin
      is_nan = (v[30:23] == 8'hff) && (v[22:0] != 23'h0);
    end
  endfunction

  // The quiet bit is the top fraction bit of the chosen format.
  function automatic logic is_quiet(input logic [63:0] v, input logic dbl);
    is_quiet = dbl ? v[51] : v[22];
  endfunction

  logic [63:0] a_w;
  logic [63:0] b_w;
  logic a_nan;
  logic b_nan;
  logic a_snan;
  logic b_snan;
  logic fmt_ok;
  logic a_ge_b;
  logic mag_gt;
  logic mag_eq;
  logic pick_a;
  logic [63:0] sel;
  logic [63:0] sel_w;
  fms_rsp_t rsp_d;
  fms_rsp_t rsp_q;

  always_comb
  begin
    a_w = widen(req_in.first_source_operand, req_in.is_double);
    b_w = widen(req_in.second_source_operand, req_in.is_double);
    a_nan = is_nan(req_in.first_source_operand, req_in.is_double);
    b_nan = is_nan(req_in.second_source_operand, req_in.is_double);
    a_snan = a_nan && !is_quiet(req_in.first_source_operand, req_in.is_double);
    b_snan = b_nan && !is_quiet(req_in.second_source_operand, req_in.is_double);
    fmt_ok = req_in.is_double ? DOUBLE_IMPL : SINGLE_IMPL;
    a_ge_b = order_key(a_w) >= order_key(b_w);
    mag_gt = a_w[62:0] > b_w[62:0];
    mag_eq = a_w[62:0] == b_w[62:0];
    pick_a = 1'b1;
    unique case (req_in.op)
      FMS_OP_MAX: pick_a = a_ge_b;
      FMS_OP_MIN: pick_a = !a_ge_b || (a_w == b_w);
      FMS_OP_MAX_MAG: pick_a = mag_gt || (mag_eq && a_ge_b);
      FMS_OP_MIN_MAG: pick_a = (!mag_gt && !mag_eq) || (mag_eq && !a_ge_b);
      default: pick_a = 1'b1;
    endcase
    if (a_nan && b_nan)
    begin
      pick_a = 1'b1;
    end
    else if (a_nan)
    begin
      pick_a = 1'b0;
    end
    else if (b_nan)
    begin
      pick_a = 1'b1;
    end
    sel = pick_a ? req_in.first_source_operand : req_in.second_source_operand;
    sel_w = widen(sel, req_in.is_double);

    rsp_d = '0;
    rsp_d.valid = req_in.valid;
    rsp_d.dest = req_in.dest;
    rsp_d.is_double = req_in.is_double;
    rsp_d.destination_operand = req_in.is_double ? sel : {32'h0, sel[31:0]};
    if (req_in.valid)
    begin
      if (!cop1_enable_in)
      begin
        rsp_d.exc_cop_unusable = 1'b1;
        rsp_d.exc_cop_num = 2'(FMS_COP_FPU);
      end
      else if (!fmt_ok)
      begin
        rsp_d.exc_reserved = 1'b1;
      end
      else if ((a_snan || b_snan) && invalid_trap_en_in)
      begin
        rsp_d.exc_invalid_trap = 1'b1;
        rsp_d.flag_invalid = 1'b1;
      end
      else
      begin
        rsp_d.write_en = 1'b1;
        rsp_d.flag_invalid = a_snan || b_snan;
      end
    end
    rsp_d.flag_inexact = 1'b0;
    rsp_d.flag_overflow = 1'b0;
    rsp_d.flag_underflow = 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rsp_q <= '0;
    end
    else
    begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_out = rsp_q;

  property p_trap_blocks_write;
    @(posedge clk_in) disable iff (!rst_n_in)
    rsp_out.exc_invalid_trap |-> !rsp_out.write_en && rsp_out.flag_invalid;
  endproperty
  a_trap_blocks_write: assert property (p_trap_blocks_write) else $error("trap with write");

  property p_cop_first;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && !cop1_enable_in) |=> rsp_out.exc_cop_unusable && !rsp_out.write_en
      && !rsp_out.exc_reserved && rsp_out.exc_cop_num == 2'h1;
  endproperty
  a_cop_first: assert property (p_cop_first) else $error("cop unusable missed");

  property p_reserved;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && cop1_enable_in && !fmt_ok) |=> rsp_out.exc_reserved && !rsp_out.write_en;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved missed");

  property p_no_flags;
    @(posedge clk_in) disable iff (!rst_n_in)
    !(rsp_out.flag_inexact || rsp_out.flag_overflow || rsp_out.flag_underflow);
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("forbidden flag");

  property p_both_nan;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && a_nan && b_nan) |=> rsp_out.destination_operand[31:0]
      == $past(req_in.first_source_operand[31:0]);
  endproperty
  a_both_nan: assert property (p_both_nan) else $error("first NaN not kept");

  property p_one_nan;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && a_nan && !b_nan) |=> rsp_out.destination_operand[31:0]
      == $past(req_in.second_source_operand[31:0]);
  endproperty
  a_one_nan: assert property (p_one_nan) else $error("numeric not returned");

  property p_max_ge;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && req_in.op == FMS_OP_MAX && !a_nan && !b_nan)
      |-> (order_key(widen(sel, req_in.is_double)) >= order_key(a_w))
      && (order_key(widen(sel, req_in.is_double)) >= order_key(b_w));
  endproperty
  a_max_ge: assert property (p_max_ge) else $error("max not greatest");

  property p_min_le;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && req_in.op == FMS_OP_MIN && !a_nan && !b_nan)
      |-> (order_key(widen(sel, req_in.is_double)) <= order_key(a_w))
      && (order_key(widen(sel, req_in.is_double)) <= order_key(b_w));
  endproperty
  a_min_le: assert property (p_min_le) else $error("min not least");

  property p_max_mag;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && req_in.op == FMS_OP_MAX_MAG && !a_nan && !b_nan)
      |-> (sel_w[62:0] >= a_w[62:0]) && (sel_w[62:0] >= b_w[62:0]);
  endproperty
  a_max_mag: assert property (p_max_mag) else $error("max magnitude not largest");

  property p_min_mag;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && req_in.op == FMS_OP_MIN_MAG && !a_nan && !b_nan)
      |-> (sel_w[62:0] <= a_w[62:0]) && (sel_w[62:0] <= b_w[62:0]);
  endproperty
  a_min_mag: assert property (p_min_mag) else $error("min magnitude not smallest");

  property p_snan_untrapped;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && cop1_enable_in && fmt_ok && !invalid_trap_en_in && (a_snan || b_snan))
      |=> rsp_out.write_en && rsp_out.flag_invalid && !rsp_out.exc_invalid_trap;
  endproperty
  a_snan_untrapped: assert property (p_snan_untrapped) else $error("untrapped sNaN lost");

  property p_single_upper;
    @(posedge clk_in) disable iff (!rst_n_in)
    (req_in.valid && !req_in.is_double) |=> rsp_out.destination_operand[63:32] == 32'h0;
  endproperty
  a_single_upper: assert property (p_single_upper) else $error("single result too wide");
endmodule
`default_nettype wire

// File: common/fms_pkg.sv
/*
 Shared types and constants for the floating-point min/max selection unit.
 Assumes the issuing pipeline supplies operands and control in one cycle.
*/
package fms_pkg;
  localparam int FMS_SP_W = 32;
  localparam int FMS_DP_W = 64;
  localparam int FMS_COP_FPU = 1;
  localparam logic [63:0] FMS_RESULT_RST = 64'h0;
  localparam logic [1:0] FMS_LATENCY = 2'h1;

  typedef enum logic [3:0] {
    FMS_OP_MAX = 4'h1,
    FMS_OP_MIN = 4'h2,
    FMS_OP_MAX_MAG = 4'h4,
    FMS_OP_MIN_MAG = 4'h8
  } fms_op_t;

  typedef struct packed {
    logic valid;
    fms_op_t op;
    logic is_double;
    logic [4:0] dest;
    logic [63:0] first_source_operand;
    logic [63:0] second_source_operand;
  } fms_req_t;

  typedef struct packed {
    logic valid;
    logic write_en;
    logic [4:0] dest;
    logic is_double;
    logic [63:0] destination_operand;
    logic exc_cop_unusable;
    logic [1:0] exc_cop_num;
    logic exc_reserved;
    logic exc_invalid_trap;
    logic flag_invalid;
    logic flag_unimpl;
    logic flag_inexact;
    logic flag_overflow;
    logic flag_underflow;
  } fms_rsp_t;
endpackage

// File: verification/fms_regfile_model.sv
/*
 Register file model on the far side of the selection unit.
 Assumes rsp_in is driven by the unit and rd_idx_in by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module fms_regfile_model
  import fms_pkg::*;
(
  input wire logic clk_in,
  input wire fms_rsp_t rsp_in,
  input wire logic [4:0] rd_idx_in,
  output logic [63:0] rd_data_out
);
  logic [63:0] mem_q [32];
  // Only a response with its write enable may change a register.
  always_ff @(posedge clk_in)
  begin
    if (rsp_in.valid && rsp_in.write_en)
    begin
      mem_q[rsp_in.dest] <= rsp_in.destination_operand;
    end
  end
  assign rd_data_out = mem_q[rd_idx_in];
endmodule
`default_nettype wire

// File: verification/fp_min_max_select_tb.sv
/*
 Self-checking bench for the selection unit.
 Assumes one-cycle latency and a response that stands one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fp_min_max_select_tb
  import fms_pkg::*;
;
  logic clk_in, rst_n_in, cop, trap;
  fms_req_t req;
  fms_rsp_t rsp;
  fms_rsp_t rsp_sp;
  logic [4:0] rd_idx;
  logic [63:0] rd_data;
  int err_count = 0;
  int num_checks = 0;
  fms_select u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .cop1_enable_in(cop), .invalid_trap_en_in(trap), .rsp_out(rsp));
  // A second unit without the double format exercises the refusal path.
  fms_select #(.SINGLE_IMPL(1'b1), .DOUBLE_IMPL(1'b0)) u_dut_sp (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .req_in(req), .cop1_enable_in(cop), .invalid_trap_en_in(trap),
    .rsp_out(rsp_sp));
  fms_regfile_model u_rf (.clk_in(clk_in), .rsp_in(rsp), .rd_idx_in(rd_idx),
    .rd_data_out(rd_data));
  initial
  begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input fms_op_t o, input logic d, input logic [63:0] a, b);
    @(negedge clk_in);
    req = {1'b1, o, d, 5'h3, a, b};
    @(negedge clk_in);
    req.valid = 0;
  endtask
  // Issues one request and checks the written value and the clean flags.
  task automatic sel(input fms_op_t o, input logic d, input logic [63:0] a, b, e);
    run(o, d, a, b);
    chk(rsp.destination_operand, e);
    chk(64'({rsp.dest, rsp.is_double}), {58'h0, 5'h3, d});
    chk(64'({rsp.valid, rsp.write_en, rsp.flag_inexact, rsp.flag_overflow,
      rsp.flag_underflow, rsp.exc_reserved, rsp.flag_unimpl}), 64'h60);
  endtask
  task automatic t_plain();
    sel(FMS_OP_MAX, 0, 64'hc0400000, 64'h40000000, 64'h40000000);
    sel(FMS_OP_MIN, 0, 64'hc0400000, 64'h40000000, 64'hc0400000);
    sel(FMS_OP_MAX_MAG, 0, 64'hc0400000, 64'h40000000, 64'hc0400000);
    sel(FMS_OP_MIN_MAG, 0, 64'hc0400000, 64'h40000000, 64'h40000000);
    sel(FMS_OP_MAX_MAG, 1, 64'h3ff0000000000000, 64'hc010000000000000,
      64'hc010000000000000);
    sel(FMS_OP_MAX, 1, 64'h3ff0000000000000, 64'hc010000000000000,
      64'h3ff0000000000000);
  endtask
  task automatic t_ties();
    sel(FMS_OP_MAX_MAG, 0, 64'hc0000000, 64'h40000000, 64'h40000000);
    sel(FMS_OP_MIN_MAG, 0, 64'h40000000, 64'hc0000000, 64'hc0000000);
    sel(FMS_OP_MAX, 0, 64'h80000000, 64'h0, 64'h0);
    sel(FMS_OP_MIN, 0, 64'h0, 64'h80000000, 64'h80000000);
    sel(FMS_OP_MAX_MAG, 0, 64'h0, 64'h80000000, 64'h0);
    sel(FMS_OP_MIN_MAG, 0, 64'h80000000, 64'h0, 64'h80000000);
  endtask
  task automatic t_nan();
    sel(FMS_OP_MIN, 0, 64'h7fc00000, 64'h3f800000, 64'h3f800000);
    sel(FMS_OP_MAX_MAG, 0, 64'h3f800000, 64'h7fc00000, 64'h3f800000);
    sel(FMS_OP_MAX, 0, 64'hffc00001, 64'h7fc00000, 64'hffc00001);
  endtask
  task automatic t_trap();
    sel(FMS_OP_MIN, 0, 64'h7f800001, 64'hffc00000, 64'h7f800001);
    chk(64'(rsp.flag_invalid), 64'h1);
    trap = 1;
    run(FMS_OP_MAX, 0, 64'h7f800001, 64'h3f800000);
    chk(64'({rsp.write_en, rsp.exc_invalid_trap}), 64'h1);
    // A write of the refused result would land on the next rising edge.
    @(negedge clk_in);
    chk(rd_data, 64'h7f800001);
    trap = 0;
    cop = 0;
    run(FMS_OP_MAX, 1, 64'h0, 64'h0);
    chk(64'({rsp.write_en, rsp.exc_cop_unusable, rsp.exc_cop_num}), 64'h5);
    chk(64'({rsp_sp.exc_cop_unusable, rsp_sp.exc_reserved, rsp_sp.write_en}), 64'h4);
    cop = 1;
  endtask
  task automatic t_fmt();
    run(FMS_OP_MIN, 1, 64'h3ff0000000000000, 64'hc010000000000000);
    chk(64'({rsp_sp.valid, rsp_sp.write_en, rsp_sp.exc_reserved}), 64'h5);
    chk(64'({rsp.write_en, rsp.exc_reserved}), 64'h2);
    run(FMS_OP_MIN, 0, 64'h3f800000, 64'h40000000);
    chk(64'({rsp_sp.write_en, rsp_sp.exc_reserved}), 64'h2);
    chk(rsp_sp.destination_operand, 64'h3f800000);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    rst_n_in = 0;
    cop = 1;
    trap = 0;
    req = '0;
    rd_idx = 5'h3;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1;
    t_plain();
    t_ties();
    t_nan();
    t_trap();
    t_fmt();
    wrap_up();
  end
endmodule
`default_nettype wire
